/* common/hpc_pkg.sv */
package hpc_pkg;
  // ==========================================================
  // Widths
  localparam int POS_W = 32;
  localparam int SPD_W = 16;
  localparam int DIN_W = 8;

  // ==========================================================
  // Digital input bit positions (after force-on masking)
  localparam int DIN_FWD_START = 0;   // forward_start_input
  localparam int DIN_REV_START = 1;
  localparam int DIN_AUTO_MODE = 2;   // automatic_mode_input
  localparam int DIN_HOME_START = 3;

  // ==========================================================
  // Setting encodings
  localparam logic COORD_ABSOLUTE = 1'b0;
  localparam logic COORD_INCREMENTAL = 1'b1;
  localparam logic [1:0] HOME_METHOD_PROX = 2'h0;
  localparam logic [1:0] FEED_X1 = 2'h0;
  localparam logic [1:0] FEED_X10 = 2'h1;
  localparam logic [1:0] FEED_X100 = 2'h2;
  localparam logic [1:0] FEED_X1000 = 2'h3;
  localparam logic [POS_W-1:0] FACTOR_X1 = 32'h0000_0001;
  localparam logic [POS_W-1:0] FACTOR_X10 = 32'h0000_000A;
  localparam logic [POS_W-1:0] FACTOR_X100 = 32'h0000_0064;
  localparam logic [POS_W-1:0] FACTOR_X1000 = 32'h0000_03E8;
  // Largest target magnitude in feed units (999999)
  localparam logic signed [POS_W-1:0] TARGET_LIMIT = 32'sh000F_423F;

  // ==========================================================
  // Reset values
  localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
  localparam logic [SPD_W-1:0] SPD_RESET = 16'h0000;
  localparam logic [DIN_W-1:0] DIN_RESET = 8'h00;

  // ==========================================================
  // Settings that only take effect after a power cycle
  typedef struct packed {
    logic command_coordinate_type;
    logic position_retention_enable;
    logic [1:0] feed_scale_select;
    logic rotation_sense_select;
    logic [1:0] homing_method_select;
    logic homing_count_sense;
    logic signed [POS_W-1:0] home_coordinate_value;
    logic [DIN_W-1:0] input_force_on_mask;
    logic proximity_switch_polarity;
  } hpc_cfg_s;

  localparam hpc_cfg_s CFG_RESET = '0;

  // Settings that act immediately
  typedef struct packed {
    logic [SPD_W-1:0] homing_speed;
    logic [SPD_W-1:0] creep_speed;
    logic [SPD_W-1:0] jog_speed;
    logic [SPD_W-1:0] move_speed;
    logic [POS_W-1:0] home_offset_distance;
  } hpc_live_s;

  // Encoder and proximity switch
  typedef struct packed {
    logic step_up;
    logic step_down;
    logic z_marker;
    logic prox_switch;
  } hpc_enc_s;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_IDLE,
    ST_JOG,
    ST_MOVE,
    ST_HOME_FAST,
    ST_HOME_CREEP
  } hpc_state_e;
endpackage

/* rtl/hpc_homing_positioning.sv */
`timescale 1ns/1ps
// Function
// R1: Coordinate type 0 means absolute targets, 1 means incremental from current position.
// R2: Retention 0 needs homing for valid position; 1 loads stored absolute position.
// R3: Feed scale 0..3 gives factors 1, 10, 100, 1000 and target ranges.
// R4: Home coordinate value is scaled by the feed factor into micrometres.
// R5: Forward start turns anticlockwise with sense 0, clockwise with sense 1.
// R6: Homing method 0 uses the proximity switch before Z-phase search.
// R7: Home return runs at homing speed until first Z-phase marker.
// R8: After the first Z-phase marker, approach home at creep speed.
// R9: Home offset is micrometres from Z-phase to home; zero point unchanged.
// R10: Home return ends there; position takes scaled home coordinate value.
// R11: Inputs selected by force-on mask read as 1 regardless of pins.
// R12: Proximity switch active low with polarity 0, active high with 1.
// R13: Power-cycle settings are captured only once after reset release.
// R14: Home-complete output is set after a successful home return.
// R15: Host sets automatic mode before homing or positioning, clears it for jog.
// R16: Targets outside the active feed range are rejected.
module hpc_homing_positioning (
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Settings
  input wire hpc_pkg::hpc_cfg_s i_cfg,
  input wire hpc_pkg::hpc_live_s i_live,
  // Host side
  input wire logic [hpc_pkg::DIN_W-1:0] i_din,
  input wire logic signed [hpc_pkg::POS_W-1:0] i_target,
  input wire logic signed [hpc_pkg::POS_W-1:0] i_abs_position,
  // Encoder side
  input wire hpc_pkg::hpc_enc_s i_enc,
  // Motion command
  output logic o_run,
  output logic o_dir_cw,
  output logic [hpc_pkg::SPD_W-1:0] o_speed_rpm,
  // Status
  output logic signed [hpc_pkg::POS_W-1:0] o_position,
  output logic o_position_valid,
  output logic o_home_complete_output,
  output logic o_in_position,
  output logic o_target_reject,
  output logic [hpc_pkg::DIN_W-1:0] o_din_eff
);
  typedef struct packed {
    hpc_pkg::hpc_state_e st;
    hpc_pkg::hpc_cfg_s cfg;
    logic signed [hpc_pkg::POS_W-1:0] pos;
    logic signed [hpc_pkg::POS_W-1:0] dest;
    logic [hpc_pkg::POS_W-1:0] offs_cnt;
    logic [hpc_pkg::DIN_W-1:0] din_prev;
    logic [hpc_pkg::DIN_W-1:0] din_eff;
    logic home_done;
    logic run;
    logic dir_cw;
    logic [hpc_pkg::SPD_W-1:0] speed;
    logic in_pos;
    logic reject;
  } hpc_regs_s;

  hpc_regs_s r_q;
  hpc_regs_s r_d;
  logic [hpc_pkg::DIN_W-1:0] din_eff;
  logic dog_active;
  logic fwd_rise;
  logic rev_rise;
  logic home_rise;
  logic auto_mode;
  logic signed [hpc_pkg::POS_W-1:0] tgt_scaled;
  logic tgt_ok;
  logic signed [hpc_pkg::POS_W-1:0] home_scaled;
  logic signed [hpc_pkg::POS_W-1:0] move_dest;
  logic signed [hpc_pkg::POS_W-1:0] pos_next;
  logic [hpc_pkg::POS_W-1:0] offs_next;

  // ==========================================================
  // Feed scaling of target and home coordinate
  hpc_scale u_tgt_scale (
    .i_value(i_target),
    .i_feed_scale_select(r_q.cfg.feed_scale_select),
    .o_scaled(tgt_scaled),
    .o_in_range(tgt_ok)
  );

  hpc_scale u_home_scale (
    .i_value(r_q.cfg.home_coordinate_value),
    .i_feed_scale_select(r_q.cfg.feed_scale_select),
    .o_scaled(home_scaled),
    .o_in_range()
  );

  // ==========================================================
  // Input conditioning
  // Forced bits override the pins for as long as power stays on
  assign din_eff = i_din | r_q.cfg.input_force_on_mask; // [R11]
  assign auto_mode = din_eff[hpc_pkg::DIN_AUTO_MODE];
  assign fwd_rise = din_eff[hpc_pkg::DIN_FWD_START] & ~r_q.din_prev[hpc_pkg::DIN_FWD_START];
  assign rev_rise = din_eff[hpc_pkg::DIN_REV_START] & ~r_q.din_prev[hpc_pkg::DIN_REV_START];
  assign home_rise = din_eff[hpc_pkg::DIN_HOME_START] & ~r_q.din_prev[hpc_pkg::DIN_HOME_START];
  // Proximity polarity decides which level means the dog is reached
  assign dog_active = r_q.cfg.proximity_switch_polarity ? i_enc.prox_switch
                                                        : ~i_enc.prox_switch; // [R12]
  // Destination depends on the latched coordinate type
  assign move_dest = (r_q.cfg.command_coordinate_type == hpc_pkg::COORD_INCREMENTAL) ?
                     r_q.pos + tgt_scaled : tgt_scaled; // [R1]

  // ==========================================================
  // Encoder position tracking; simultaneous up and down cancel
  always_comb begin
    pos_next = r_q.pos;
    if (i_enc.step_up && !i_enc.step_down) begin
      pos_next = r_q.pos + 32'sh0000_0001;
    end else if (i_enc.step_down && !i_enc.step_up) begin
      pos_next = r_q.pos - 32'sh0000_0001;
    end
    offs_next = r_q.offs_cnt;
    if (i_enc.step_up ^ i_enc.step_down) begin
      offs_next = r_q.offs_cnt + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    r_d = r_q;
    r_d.din_prev = din_eff;
    r_d.din_eff = din_eff;
    r_d.pos = pos_next;
    r_d.reject = 1'b0;
    unique case (r_q.st)
      hpc_pkg::ST_INIT: begin
        // Captured once here, so later writes to the setting pins have no effect
        r_d.cfg = i_cfg; // [R13]
        r_d.din_prev = i_din | i_cfg.input_force_on_mask;
        if (i_cfg.position_retention_enable) begin
          r_d.pos = i_abs_position; // [R2]
          r_d.home_done = 1'b1; // [R2]
        end
        r_d.st = hpc_pkg::ST_IDLE;
      end
      hpc_pkg::ST_IDLE: begin
        r_d.run = 1'b0;
        r_d.speed = hpc_pkg::SPD_RESET;
        if (!auto_mode) begin
          // Jog only while the host keeps automatic mode off
          if (din_eff[hpc_pkg::DIN_FWD_START] || din_eff[hpc_pkg::DIN_REV_START]) begin
            r_d.st = hpc_pkg::ST_JOG; // [R15]
          end
        end else if (home_rise) begin
          r_d.home_done = 1'b0;
          r_d.in_pos = 1'b0;
          r_d.run = 1'b1;
          r_d.speed = i_live.homing_speed; // [R7]
          r_d.dir_cw = r_q.cfg.rotation_sense_select ^ r_q.cfg.homing_count_sense;
          r_d.st = hpc_pkg::ST_HOME_FAST;
        end else if (fwd_rise) begin
          if (!tgt_ok) begin
            r_d.reject = 1'b1; // [R16]
          end else if (r_q.home_done) begin
            // Without a valid position a move is meaningless; refuse the start until homed
            r_d.dest = move_dest;
            r_d.in_pos = 1'b0;
            r_d.st = hpc_pkg::ST_MOVE;
          end else begin
            r_d.reject = 1'b1; // [R2]
          end
        end
      end
      hpc_pkg::ST_JOG: begin
        r_d.run = 1'b1;
        r_d.speed = i_live.jog_speed;
        // Forward start: anticlockwise at sense 0, clockwise at sense 1
        r_d.dir_cw = din_eff[hpc_pkg::DIN_FWD_START] ? r_q.cfg.rotation_sense_select
                                                     : ~r_q.cfg.rotation_sense_select; // [R5]
        if (auto_mode || !(din_eff[hpc_pkg::DIN_FWD_START] ||
                           din_eff[hpc_pkg::DIN_REV_START])) begin
          r_d.run = 1'b0;
          r_d.st = hpc_pkg::ST_IDLE;
        end
      end
      hpc_pkg::ST_MOVE: begin
        if (r_q.pos == r_q.dest) begin
          r_d.run = 1'b0;
          r_d.speed = hpc_pkg::SPD_RESET;
          r_d.in_pos = 1'b1;
          r_d.st = hpc_pkg::ST_IDLE;
        end else begin
          r_d.run = 1'b1;
          r_d.speed = i_live.move_speed;
          // Moving toward larger coordinates is the forward sense
          r_d.dir_cw = (r_q.dest > r_q.pos) ? r_q.cfg.rotation_sense_select
                                            : ~r_q.cfg.rotation_sense_select; // [R5]
        end
      end
      hpc_pkg::ST_HOME_FAST: begin
        r_d.speed = i_live.homing_speed; // [R7]
        // Dog method only accepts a marker once the switch is reached
        if (i_enc.z_marker && (dog_active ||
            r_q.cfg.homing_method_select != hpc_pkg::HOME_METHOD_PROX)) begin // [R6]
          r_d.speed = i_live.creep_speed; // [R8]
          r_d.offs_cnt = hpc_pkg::POS_RESET;
          r_d.st = hpc_pkg::ST_HOME_CREEP;
        end
      end
      hpc_pkg::ST_HOME_CREEP: begin
        r_d.speed = i_live.creep_speed; // [R8]
        r_d.offs_cnt = offs_next;
        // Offset only shifts the stop point, never the coordinate zero
        if (r_q.offs_cnt >= i_live.home_offset_distance) begin // [R9]
          r_d.run = 1'b0;
          r_d.speed = hpc_pkg::SPD_RESET;
          r_d.pos = home_scaled; // [R10] [R4]
          r_d.home_done = 1'b1; // [R14]
          r_d.st = hpc_pkg::ST_IDLE;
        end
      end
      default: begin
        r_d.st = hpc_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register; clock enable freezes everything except the synchronous reset, which acts even with enable low
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      r_q.st <= hpc_pkg::ST_INIT;
      r_q.cfg <= hpc_pkg::CFG_RESET;
      r_q.pos <= hpc_pkg::POS_RESET;
      r_q.dest <= hpc_pkg::POS_RESET;
      r_q.offs_cnt <= hpc_pkg::POS_RESET;
      r_q.din_prev <= hpc_pkg::DIN_RESET;
      r_q.din_eff <= hpc_pkg::DIN_RESET;
      r_q.home_done <= 1'b0;
      r_q.run <= 1'b0;
      r_q.dir_cw <= 1'b0;
      r_q.speed <= hpc_pkg::SPD_RESET;
      r_q.in_pos <= 1'b0;
      r_q.reject <= 1'b0;
    end else if (i_ce) begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign o_run = r_q.run;
  assign o_dir_cw = r_q.dir_cw;
  assign o_speed_rpm = r_q.speed;
  assign o_position = r_q.pos;
  assign o_position_valid = r_q.home_done;
  assign o_home_complete_output = r_q.home_done; // [R14]
  assign o_in_position = r_q.in_pos;
  assign o_target_reject = r_q.reject;
  assign o_din_eff = r_q.din_eff;
endmodule

/* rtl/hpc_scale.sv */
`timescale 1ns/1ps
// Scales a value in feed units to micrometres and checks its range
module hpc_scale (
  // Value and scale
  input wire logic signed [hpc_pkg::POS_W-1:0] i_value,
  input wire logic [1:0] i_feed_scale_select,
  // Result
  output logic signed [hpc_pkg::POS_W-1:0] o_scaled,
  output logic o_in_range
);
  logic [hpc_pkg::POS_W-1:0] factor;
  logic signed [2*hpc_pkg::POS_W-1:0] product;

  // Factor lookup; the range limit keeps the product inside 32 bits
  always_comb begin
    unique case (i_feed_scale_select)
      hpc_pkg::FEED_X1: factor = hpc_pkg::FACTOR_X1; // [R3]
      hpc_pkg::FEED_X10: factor = hpc_pkg::FACTOR_X10; // [R3]
      hpc_pkg::FEED_X100: factor = hpc_pkg::FACTOR_X100; // [R3]
      hpc_pkg::FEED_X1000: factor = hpc_pkg::FACTOR_X1000; // [R3]
    endcase
    product = i_value * $signed({1'b0, factor});
    o_scaled = product[hpc_pkg::POS_W-1:0];
    o_in_range = (i_value <= hpc_pkg::TARGET_LIMIT) && (i_value >= -hpc_pkg::TARGET_LIMIT);
  end
endmodule

/* verif/hpc_checker.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checks for the homing and positioning block
module hpc_checker (
  // Clock, reset and enable
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Inputs
  input wire hpc_pkg::hpc_cfg_s i_cfg,
  input wire hpc_pkg::hpc_live_s i_live,
  input wire logic [hpc_pkg::DIN_W-1:0] i_din,
  input wire logic signed [hpc_pkg::POS_W-1:0] i_target,
  input wire hpc_pkg::hpc_enc_s i_enc,
  // Outputs
  input wire logic o_run,
  input wire logic o_dir_cw,
  input wire logic [hpc_pkg::SPD_W-1:0] o_speed_rpm,
  input wire logic signed [hpc_pkg::POS_W-1:0] o_position,
  input wire logic o_home_complete_output,
  input wire logic o_in_position,
  input wire logic o_target_reject,
  input wire logic [hpc_pkg::DIN_W-1:0] o_din_eff
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  hpc_pkg::hpc_cfg_s cfg_q;
  logic arm_q;
  logic dog_on;
  logic signed [31:0] fac;
  // Own copy of the settings, so later writes cannot mislead the checks
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      arm_q <= 1'b1;
      cfg_q <= hpc_pkg::CFG_RESET;
    end else if (i_ce && arm_q) begin
      arm_q <= 1'b0;
      cfg_q <= i_cfg;
    end
  end
  // Scale factor and switch state under the captured settings
  assign fac = cfg_q.feed_scale_select == 2'h3 ? 32'sh3E8 : cfg_q.feed_scale_select == 2'h2 ?
    32'sh64 : cfg_q.feed_scale_select == 2'h1 ? 32'shA : 32'sh1;
  assign dog_on = i_enc.prox_switch == cfg_q.proximity_switch_polarity;
  sequence s_fwd_req;
    i_ce && !arm_q && !o_run && i_din[2] && !i_din[3] && $rose(i_din[0]);
  endsequence
  sequence s_home_req;
    i_ce && !arm_q && !o_run && i_din[2] && $rose(i_din[3]);
  endsequence
  sequence s_jog_req;
    i_ce && !arm_q && !o_run && !i_din[2] && !i_din[1] && $rose(i_din[0]) ##1 i_din[0];
  endsequence
  property p_din;
    i_ce && !arm_q && !$past(i_srst) |=>
      o_din_eff == ($past(i_din) | cfg_q.input_force_on_mask);
  endproperty
  a_din: assert property (p_din) else $error("effective inputs wrong");
  property p_home_go;
    s_home_req |=> o_run && o_speed_rpm == $past(i_live.homing_speed) && !o_home_complete_output
      && o_dir_cw == (cfg_q.rotation_sense_select ^ cfg_q.homing_count_sense);
  endproperty
  a_home_go: assert property (p_home_go) else $error("home start wrong");
  property p_creep;
    o_run && o_speed_rpm == i_live.homing_speed && i_enc.z_marker && dog_on
      |=> o_speed_rpm == $past(i_live.creep_speed);
  endproperty
  a_creep: assert property (p_creep) else $error("no creep after Z");
  property p_home_end;
    !$past(i_srst) && $fell(o_run) && $past(o_speed_rpm) == $past(i_live.creep_speed)
      |-> o_home_complete_output && o_position == cfg_q.home_coordinate_value * fac;
  endproperty
  a_home_end: assert property (p_home_end) else $error("home end wrong");
  property p_unhomed;
    s_fwd_req ##0 !o_home_complete_output |=> o_target_reject;
  endproperty
  a_unhomed: assert property (p_unhomed) else $error("unhomed move taken");
  property p_range;
    s_fwd_req ##0 (i_target > hpc_pkg::TARGET_LIMIT || i_target < -hpc_pkg::TARGET_LIMIT)
      |=> o_target_reject;
  endproperty
  a_range: assert property (p_range) else $error("far target taken");
  property p_pulse;
    o_target_reject && i_ce |=> !o_target_reject;
  endproperty
  a_pulse: assert property (p_pulse) else $error("refusal too long");
  property p_jog;
    s_jog_req |=> o_run && o_dir_cw == cfg_q.rotation_sense_select;
  endproperty
  a_jog: assert property (p_jog) else $error("jog direction wrong");
  property p_in_pos;
    $rose(o_in_position) |-> $fell(o_run) && o_speed_rpm == 16'h0000;
  endproperty
  a_in_pos: assert property (p_in_pos) else $error("arrival wrong");
endmodule

bind hpc_homing_positioning hpc_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce), .i_cfg(i_cfg), .i_live(i_live),
  .i_din(i_din), .i_target(i_target), .i_enc(i_enc), .o_run(o_run), .o_dir_cw(o_dir_cw),
  .o_speed_rpm(o_speed_rpm), .o_position(o_position), .o_in_position(o_in_position),
  .o_home_complete_output(o_home_complete_output), .o_target_reject(o_target_reject),
  .o_din_eff(o_din_eff)
);

/* verif/hpc_enc_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Motor and encoder: Z mark every 16 um, switch on from 40 um up
module hpc_enc_model (
  // Clock and command
  input wire logic i_ref_clk,
  input wire logic i_run,
  input wire logic i_dir_cw,
  // Mounting and pace
  input wire logic i_sense,
  input wire logic i_dog_pol,
  input wire logic [1:0] i_div,
  // Encoder and switch
  output hpc_pkg::hpc_enc_s o_enc
);
  int pos = 0;
  int cnt = 0;
  logic fwd;
  initial o_enc = '0;
  // A slow pace avoids overrun, since the run command is registered
  always @(posedge i_ref_clk) begin
    fwd = (i_dir_cw == i_sense);
    o_enc.step_up <= 1'b0;
    o_enc.step_down <= 1'b0;
    o_enc.z_marker <= 1'b0;
    cnt <= cnt + 1;
    if (i_run && cnt >= i_div) begin
      cnt <= 0;
      pos = fwd ? pos + 1 : pos - 1;
      o_enc.step_up <= fwd;
      o_enc.step_down <= !fwd;
      o_enc.z_marker <= (pos % 16 == 0);
    end
    o_enc.prox_switch <= (pos >= 40) ? i_dog_pol : !i_dog_pol;
  end
endmodule

/* verif/hpc_homing_positioning_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the homing and positioning block
module hpc_homing_positioning_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  hpc_pkg::hpc_cfg_s cfg = '0;
  hpc_pkg::hpc_live_s live = '{16'h0100, 16'h0010, 16'h0050, 16'h0200, 32'h0000_0003};
  logic [7:0] din = 8'h00;
  logic signed [31:0] target = '0;
  logic signed [31:0] abs_pos = 32'sh0000_04D2;
  logic sense_q = 1'b0;
  logic [1:0] div = 2'h0;
  hpc_pkg::hpc_enc_s enc;
  logic run, dir_cw, home_done, in_pos, reject, pos_valid;
  logic [15:0] speed;
  logic signed [31:0] pos;
  logic [7:0] din_eff;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  hpc_homing_positioning dut (
    .i_ref_clk(clk), .i_srst(srst), .i_ce(ce), .i_cfg(cfg), .i_live(live), .i_din(din),
    .i_target(target), .i_abs_position(abs_pos), .i_enc(enc), .o_run(run), .o_dir_cw(dir_cw),
    .o_speed_rpm(speed), .o_position(pos), .o_position_valid(pos_valid),
    .o_home_complete_output(home_done), .o_in_position(in_pos), .o_target_reject(reject),
    .o_din_eff(din_eff)
  );
  hpc_enc_model u_motor (
    .i_ref_clk(clk), .i_run(run), .i_dir_cw(dir_cw), .i_sense(sense_q),
    .i_dog_pol(cfg.proximity_switch_polarity), .i_div(div), .o_enc(enc)
  );
  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Cut a hang short; the run needs far fewer cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Power cycle with new settings
  task automatic t_power_up(input hpc_pkg::hpc_cfg_s c);
    cfg = c;
    sense_q = c.rotation_sense_select;
    din = 8'h00;
    srst = 1'b1;
    ce = 1'b1;
    step(16);
    srst = 1'b0;
    // Enable held low after release: nothing may be captured yet
    ce = 1'b0;
    step(2);
    cmp(home_done, 1'b0);
    ce = 1'b1;
    step(3);
    cmp(din_eff, c.input_force_on_mask);
    cmp(home_done, c.position_retention_enable);
    cmp(pos_valid, c.position_retention_enable);
  endtask
  // Homing at a slow pace, so no step slips past the registered stop
  task automatic t_home(input int exp);
    div = 2'h2;
    din = 8'h04;
    step(1);
    din = 8'h0C;
    step(1);
    din = 8'h04;
    for (int i = 0; i < 4000 && home_done !== 1'b1; i++) step(1);
    cmp(run, 1'b0);
    cmp(pos, exp);
    cmp(pos_valid, 1'b1);
  endtask
  // Move at a slow pace so the stop lands on the destination
  task automatic t_move(input int tgt, input int exp);
    div = 2'h2;
    target = tgt;
    din = 8'h04;
    step(1);
    din = 8'h05;
    step(1);
    din = 8'h04;
    for (int i = 0; i < 30000 && in_pos !== 1'b1; i++) step(1);
    cmp(pos, exp);
  endtask
  // Refused start gives one pulse and no motion
  task automatic t_reject(input int tgt);
    target = tgt;
    din = 8'h04;
    step(1);
    din = 8'h05;
    step(1);
    cmp(reject, 1'b1);
    din = 8'h04;
    step(1);
    cmp(reject, 1'b0);
    cmp(run, 1'b0);
  endtask
  // Jog follows the power-up sense even after a later change
  task automatic t_jog();
    din = 8'h00;
    step(1);
    cfg.rotation_sense_select = !sense_q;
    din = 8'h01;
    step(4);
    cmp(run, 1'b1);
    cmp(dir_cw, sense_q);
    din = 8'h00;
    step(2);
    cmp(run, 1'b0);
    cfg.rotation_sense_select = sense_q;
  endtask
  // Retained position counts as homed at once
  task automatic t_retain();
    hpc_pkg::hpc_cfg_s c;
    c = '0;
    c.position_retention_enable = 1'b1;
    t_power_up(c);
    cmp(pos, abs_pos);
    t_move(1230, 1230);
  endtask
  // Main sequence over all four feed scales
  initial begin
    hpc_pkg::hpc_cfg_s c;
    int fac;
    for (int f = 0; f < 4; f++) begin
      fac = (f == 0) ? 1 : (f == 1) ? 10 : (f == 2) ? 100 : 1000;
      c = '0;
      c.feed_scale_select = f[1:0];
      c.command_coordinate_type = f[0];
      c.rotation_sense_select = f[0];
      c.proximity_switch_polarity = f[1];
      // Last pass takes the first marker without waiting for the switch
      c.homing_method_select = (f == 3) ? 2'h1 : hpc_pkg::HOME_METHOD_PROX;
      c.home_coordinate_value = 32'sh0000_0005;
      c.input_force_on_mask = 8'hA0;
      t_power_up(c);
      t_reject(1);
      t_home(5 * fac);
      t_move(2, f[0] ? 7 * fac : 2 * fac);
      t_reject(f[0] ? 1000000 : -1000000);
      t_jog();
    end
    t_retain();
    give_verdict();
  end
endmodule
